/* logic/lcs_pkg.sv */
// constants for the loopback and clock select block
package lcs_pkg;
   localparam int CLK_PERIOD_NS   = 4;
   // lock window, least time, rounded up to whole cycles
   localparam int LOCK_WINDOW_NS  = 1500;
   localparam int LOCK_WINDOW_CYC =
      (LOCK_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [8:0] LOCK_WINDOW = 9'(LOCK_WINDOW_CYC);

   localparam int BYTE_BITS = 8;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam logic [7:0] LOS_RUN_BITS    = 8'h80;
   localparam logic [7:0] LOS_WINDOW_LAST = 8'h7f;
   localparam logic [7:0] LOS_CLEAR_TRANS = 8'h10;
   localparam logic [7:0] RUN_HOLD_BITS   = 8'h64;

   // feedback divider per reference rate
   localparam logic [5:0] DIV_REF_19M = 6'h20;
   localparam logic [5:0] DIV_REF_38M = 6'h10;
   localparam logic [5:0] DIV_REF_51M = 6'h0c;
   localparam logic [5:0] DIV_REF_77M = 6'h08;
   localparam logic [2:0] RATE_19M = 3'h6;
   localparam logic [2:0] RATE_38M = 3'h2;
   localparam logic [2:0] RATE_51M = 3'h1;
   localparam logic [2:0] RATE_77M = 3'h0;
   localparam logic [5:0] PHASE_TOL_CYC = 6'h02;

   // register map
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [31:0] CTRL_RESET = 32'h0;
   localparam int CTL_LINE_LOOP = 0;
   localparam int CTL_HOST_LOOP = 1;
   localparam int CTL_REC_LOOP  = 2;
   localparam int CTL_BYPASS    = 3;
   localparam int CTL_REFSEL    = 4;
   localparam int CTL_REC_REF   = 5;
   localparam int CTL_RATE_LSB  = 8;
   localparam int CTL_HIGH_RATE = 11;
   localparam int ST_LOS        = 0;
   localparam int ST_REC_LOCK   = 1;
   localparam int ST_REFSEL_ACT = 2;
   localparam int ST_SYNTH_LOCK = 3;
   localparam int ST_HIGH_RATE  = 4;
   localparam int ST_DIV_LSB    = 8;
endpackage : lcs_pkg

/* logic/lcs_synth_ref.sv */
// multiplier reference select, feedback divider and lock pulses
`timescale 1ns/1ps
module lcs_synth_ref
   import lcs_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       mult_clock,
   input  wire logic       ref_ttl,
   input  wire logic       ref_diff_p,
   input  wire logic       ref_diff_n,
   input  wire logic       rx_div8,
   input  wire logic       refsel_active,
   input  wire logic [2:0] rate_select_pins,
   output logic [5:0]      fb_div,
   output logic            synth_lock_indicator
);
   logic       ref_sel;
   logic       ref_prev, mclk_prev, ref_edge, mclk_edge;
   logic [5:0] fb_cnt, win, next_fb_cnt, next_win;
   logic       next_pulse, pulse;

   always_comb begin
      unique case (rate_select_pins)
         RATE_19M: fb_div = DIV_REF_19M;
         RATE_38M: fb_div = DIV_REF_38M;
         RATE_51M: fb_div = DIV_REF_51M;
         RATE_77M: fb_div = DIV_REF_77M;
         default:  fb_div = DIV_REF_77M;
      endcase
   end

   // receive clock over eight replaces it
   assign ref_sel = refsel_active ? rx_div8
                                  : ~((ref_diff_p & ~ref_diff_n) ^ ref_ttl);
   assign ref_edge  = ref_sel & ~ref_prev;
   assign mclk_edge = mult_clock & ~mclk_prev;

   always_comb begin
      next_fb_cnt = fb_cnt;
      next_win    = (win == 6'h3f) ? win : win + 6'h01;
      next_pulse  = 1'b0;
      if (ref_edge)
         next_win = 6'h00;
      if (mclk_edge)
         next_fb_cnt = (fb_cnt == fb_div - 6'h01) ? 6'h00 : fb_cnt + 6'h01;
      // low pulse when divided edge meets reference
      if (mclk_edge && fb_cnt == fb_div - 6'h01 &&
          (ref_edge || win < PHASE_TOL_CYC))
         next_pulse = 1'b1;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ref_prev  <= 1'b0;
         mclk_prev <= 1'b0;
         fb_cnt    <= 6'h00;
         win       <= 6'h3f;
         pulse     <= 1'b0;
      end else begin
         ref_prev  <= ref_sel;
         mclk_prev <= mult_clock;
         fb_cnt    <= next_fb_cnt;
         win       <= next_win;
         pulse     <= next_pulse;
      end
   end

   assign synth_lock_indicator = ~pulse;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   property p_pulse_single;
      !synth_lock_indicator |=> synth_lock_indicator;
   endproperty
   a_pulse_single: assert property (p_pulse_single)
      else $error("lock pulse wider than one cycle");

   property p_div_32;
      rate_select_pins == RATE_19M |-> fb_div == 6'h20;
   endproperty
   a_div_32: assert property (p_div_32)
      else $error("divider not 32 at lowest reference");
endmodule : lcs_synth_ref

/* logic/lcs_top.sv */
// loopback routing, loop timing, clock select and lock monitors
`timescale 1ns/1ps
// Function
// - recovery loop feeds own serial transmit stream into clock recovery
// - both loops: serial input and clock go to serial outputs
// - both loops: transmit byte bus and clock go to byte outputs
// - bypass mode replaces multiplier clock with serial receive clock
// - reference-select mode uses receive clock over eight as reference
// - reference-select mode drops out on loss of signal or host loop
// - rate pins set feedback divider 32, 16, 12 or 8
// - multiplier lock indicator pulses low while phase aligned
// - multiplier reference is xnor of differential and single references
// - recovery reference select picks multiplier or own reference
// - recovery lock asserts after clean 1.5 us window
// - recovery lock drops at once on dropped bit or drift
// - recovery lock survives up to 100 bits without transition
// - line loop passes serial data out and still deserializes it
// - host loop deserializes own transmit bits, multiplier byte clock
// - loss after over 128 flat bits, cleared by over 16 transitions
module lcs_top
   import lcs_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_cyc_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        serial_rx_in,
   input  wire logic        serial_rx_clock_in,
   output logic             serial_tx_out,
   output logic             serial_tx_clock_out,
   input  wire logic [7:0]  byte_tx_bus,
   input  wire logic        byte_tx_clock_in,
   output logic [7:0]       byte_rx_bus,
   output logic             byte_rx_clock_out,
   input  wire logic        synth_reference_clock,
   input  wire logic        differential_reference_clock_p,
   input  wire logic        differential_reference_clock_n,
   input  wire logic        recovery_reference_clock,
   input  wire logic        mult_clock,
   input  wire logic        dropped_bit,
   input  wire logic        drift_excess,
   output logic             synth_lock_indicator,
   output logic             recovery_lock_indicator,
   output logic             recovery_reference_out
);
   logic [31:0] ctrl, next_ctrl, next_dat;
   logic        next_ack;
   logic        line_loop, host_loop, rec_loop, bypass, split_loop;
   logic        refsel_active;
   logic [5:0]  fb_div;

   // serialize / deserialize state
   logic [7:0]  tx_hold, tx_shift, rx_shift;
   logic [7:0]  next_tx_hold, next_tx_shift, next_rx_shift, next_rx_bus;
   logic [2:0]  tx_cnt, rx_cnt, next_tx_cnt, next_rx_cnt;
   logic        txclk_prev, rxclk_prev;
   logic [2:0]  rxclk_cnt, next_rxclk_cnt;
   logic        tx_bit, cru_in, des_in;
   logic        next_ser_out, next_ser_clk, next_byte_clk, next_rec_ref;

   // loss of signal and recovery lock state
   logic        los, next_los, cru_prev, transition;
   logic [7:0]  run, next_run, lwin, next_lwin, ltrans, next_ltrans;
   logic [8:0]  lock_cnt, next_lock_cnt;
   logic        next_lock;

   assign line_loop  = ctrl[CTL_LINE_LOOP];
   assign host_loop  = ctrl[CTL_HOST_LOOP];
   assign rec_loop   = ctrl[CTL_REC_LOOP];
   assign bypass     = ctrl[CTL_BYPASS];
   assign split_loop = line_loop & host_loop;
   // forced out so the multiplier never locks to itself
   assign refsel_active = ctrl[CTL_REFSEL] & ~los & ~host_loop & ~rec_loop;

   // ---------------- register slave ----------------
   always_comb begin
      next_ctrl = ctrl;
      next_ack  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      next_dat  = wb_dat_o;
      if (next_ack) begin
         next_dat = 32'h0;
         if (wb_adr_i == ADDR_CTRL) begin
            next_dat = ctrl;
            if (wb_we_i) begin
               for (int i = 0; i < 4; i++)
                  if (wb_sel_i[i])
                     next_ctrl[i*8 +: 8] = wb_dat_i[i*8 +: 8];
            end
         end else if (wb_adr_i == ADDR_STATUS) begin
            next_dat[ST_LOS]        = los;
            next_dat[ST_REC_LOCK]   = recovery_lock_indicator;
            next_dat[ST_REFSEL_ACT] = refsel_active;
            next_dat[ST_SYNTH_LOCK] = synth_lock_indicator;
            next_dat[ST_HIGH_RATE]  = ctrl[CTL_HIGH_RATE];
            next_dat[ST_DIV_LSB +: 6] = fb_div;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl     <= CTRL_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ctrl     <= next_ctrl;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat;
      end
   end

   // ---------------- multiplier reference ----------------
   lcs_synth_ref lcs_synth_ref_inst (
      .clk                  (clk),
      .rst_b                (rst_b),
      // receive clock stands in for the multiplier in bypass
      .mult_clock           (bypass ? serial_rx_clock_in : mult_clock),
      .ref_ttl              (synth_reference_clock),
      .ref_diff_p           (differential_reference_clock_p),
      .ref_diff_n           (differential_reference_clock_n),
      .rx_div8              (rxclk_cnt[2]),
      .refsel_active        (refsel_active),
      .rate_select_pins     (ctrl[CTL_RATE_LSB +: 3]),
      .fb_div               (fb_div),
      .synth_lock_indicator (synth_lock_indicator)
   );

   // ---------------- serial datapaths ----------------
   // one clk cycle stands for one serial bit time
   assign tx_bit = tx_shift[7];
   // loop closes ahead of clock recovery
   assign cru_in = rec_loop ? tx_bit : serial_rx_in;
   // host loop bypasses recovery; loss forces data low
   assign des_in = host_loop ? tx_bit : (cru_in & ~los);

   always_comb begin
      next_tx_hold = tx_hold;
      if (byte_tx_clock_in && !txclk_prev)
         next_tx_hold = byte_tx_bus;
      next_tx_cnt   = tx_cnt + 3'h1;
      next_tx_shift = (tx_cnt == LAST_BIT) ? tx_hold
                                           : {tx_shift[6:0], 1'b0};
      next_rx_cnt   = rx_cnt + 3'h1;
      next_rx_shift = {rx_shift[6:0], des_in};
      next_rx_bus   = byte_rx_bus;
      if (rx_cnt == LAST_BIT)
         next_rx_bus = {rx_shift[6:0], des_in};
      next_byte_clk = host_loop ? tx_cnt[2] : rx_cnt[2];
      // split loop wraps byte side straight round
      if (split_loop) begin
         next_rx_bus   = byte_tx_bus;
         next_byte_clk = byte_tx_clock_in;
      end
      // line loop wraps serial data and clock out
      next_ser_out = line_loop ? serial_rx_in : tx_bit;
      if (line_loop || bypass)
         next_ser_clk = serial_rx_clock_in;
      else
         next_ser_clk = mult_clock;
      next_rxclk_cnt = rxclk_cnt;
      if (serial_rx_clock_in && !rxclk_prev)
         next_rxclk_cnt = rxclk_cnt + 3'h1;
      next_rec_ref = ctrl[CTL_REC_REF] ? recovery_reference_clock
                                       : ~((differential_reference_clock_p &
                                            ~differential_reference_clock_n)
                                           ^ synth_reference_clock);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tx_hold                <= 8'h00;
         tx_shift               <= 8'h00;
         tx_cnt                 <= 3'h0;
         rx_shift               <= 8'h00;
         rx_cnt                 <= 3'h0;
         byte_rx_bus            <= 8'h00;
         byte_rx_clock_out      <= 1'b0;
         serial_tx_out          <= 1'b0;
         serial_tx_clock_out    <= 1'b0;
         txclk_prev             <= 1'b0;
         rxclk_prev             <= 1'b0;
         rxclk_cnt              <= 3'h0;
         recovery_reference_out <= 1'b0;
      end else begin
         tx_hold                <= next_tx_hold;
         tx_shift               <= next_tx_shift;
         tx_cnt                 <= next_tx_cnt;
         rx_shift               <= next_rx_shift;
         rx_cnt                 <= next_rx_cnt;
         byte_rx_bus            <= next_rx_bus;
         byte_rx_clock_out      <= next_byte_clk;
         serial_tx_out          <= next_ser_out;
         serial_tx_clock_out    <= next_ser_clk;
         txclk_prev             <= byte_tx_clock_in;
         rxclk_prev             <= serial_rx_clock_in;
         rxclk_cnt              <= next_rxclk_cnt;
         recovery_reference_out <= next_rec_ref;
      end
   end

   // ---------------- loss of signal and recovery lock ----------------
   assign transition = cru_in ^ cru_prev;

   always_comb begin
      next_run    = transition ? 8'h00
                  : (run == 8'hff ? run : run + 8'h01);
      next_los    = los;
      next_lwin   = lwin + 8'h01;
      next_ltrans = (transition && ltrans != 8'hff) ? ltrans + 8'h01 : ltrans;
      // declare after more than 128 flat bits
      if (!los && !transition && run == LOS_RUN_BITS) begin
         next_los    = 1'b1;
         next_lwin   = 8'h00;
         next_ltrans = 8'h00;
      end else if (los && lwin == LOS_WINDOW_LAST) begin
         // clear on more than 16 transitions per window
         if (next_ltrans > LOS_CLEAR_TRANS)
            next_los = 1'b0;
         next_lwin   = 8'h00;
         next_ltrans = 8'h00;
      end
      // dropped bit or drift clears lock at once
      // flat runs up to the hold length keep lock
      if (dropped_bit || drift_excess || los || run > RUN_HOLD_BITS)
         next_lock_cnt = 9'h000;
      else if (lock_cnt == LOCK_WINDOW)
         next_lock_cnt = lock_cnt;
      else
         next_lock_cnt = lock_cnt + 9'h001;
      // assert once a whole clean window has passed
      next_lock = (next_lock_cnt == LOCK_WINDOW);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         los                     <= 1'b0;
         cru_prev                <= 1'b0;
         run                     <= 8'h00;
         lwin                    <= 8'h00;
         ltrans                  <= 8'h00;
         lock_cnt                <= 9'h000;
         recovery_lock_indicator <= 1'b0;
      end else begin
         los                     <= next_los;
         cru_prev                <= cru_in;
         run                     <= next_run;
         lwin                    <= next_lwin;
         ltrans                  <= next_ltrans;
         lock_cnt                <= next_lock_cnt;
         recovery_lock_indicator <= next_lock;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ack_pulse;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   property p_ack;
      s_req |=> s_ack_pulse;
   endproperty
   a_ack: assert property (p_ack)
      else $error("bus answer not one cycle after request");

   property p_lock_drop;
      dropped_bit || drift_excess |=> !recovery_lock_indicator;
   endproperty
   a_lock_drop: assert property (p_lock_drop)
      else $error("recovery lock held after error event");

   property p_refsel_exit;
      los || host_loop |-> !refsel_active;
   endproperty
   a_refsel_exit: assert property (p_refsel_exit)
      else $error("reference select mode kept during loss or loop");

   property p_split;
      split_loop |=> byte_rx_bus == $past(byte_tx_bus);
   endproperty
   a_split: assert property (p_split)
      else $error("split loop byte bus not wrapped");

   property p_line;
      line_loop |=> serial_tx_out == $past(serial_rx_in);
   endproperty
   a_line: assert property (p_line)
      else $error("line loop serial data not wrapped");

   property p_bypass;
      bypass |=> serial_tx_clock_out == $past(serial_rx_clock_in);
   endproperty
   a_bypass: assert property (p_bypass)
      else $error("bypass clock not taken from receive clock");

   property p_los_set;
      !los && !transition && run == LOS_RUN_BITS |=> los;
   endproperty
   a_los_set: assert property (p_los_set)
      else $error("loss not declared after flat run");
endmodule : lcs_top

/* test/lcs_partner.sv */
// far side model: serial optics and byte-wide network device
`timescale 1ns/1ps
module lcs_partner (
   input  wire logic       clk,
   input  wire logic       rst_b,
   input  wire logic       quiet,
   input  wire logic [7:0] tx_byte,
   output logic            serial_rx_in,
   output logic            serial_rx_clock_in,
   output logic [7:0]      byte_tx_bus,
   output logic            byte_tx_clock_in,
   output logic            synth_reference_clock,
   output logic            differential_reference_clock_p,
   output logic            differential_reference_clock_n,
   output logic            recovery_reference_clock,
   output logic            mult_clock
);
   logic [3:0] div;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div <= 4'h0;
         serial_rx_in <= 1'b0;
         serial_rx_clock_in <= 1'b0;
         byte_tx_bus <= 8'h00;
         byte_tx_clock_in <= 1'b0;
         // opposite phase to the receive clock, so bypass is visible
         mult_clock <= 1'b1;
      end else begin
         div <= div + 4'h1;
         serial_rx_clock_in <= ~serial_rx_clock_in;
         mult_clock <= ~mult_clock;
         // quiet line models lost optical power
         serial_rx_in <= quiet ? 1'b0 : ~serial_rx_in;
         byte_tx_clock_in <= div[2];
         // byte changes away from the rising byte clock edge
         if (div[2:0] == 3'h1) begin
            byte_tx_bus <= tx_byte;
         end
      end
   end

   assign synth_reference_clock = div[3];
   assign differential_reference_clock_p = div[2];
   assign differential_reference_clock_n = ~div[2];
   assign recovery_reference_clock = div[1];
endmodule : lcs_partner

/* test/testbench.sv */
// self-checking bench for the loopback and clock select block
`timescale 1ns/1ps
`define CHECK(a, b) begin \
   tests_run++; \
   if ((a) !== (b)) begin \
      fails++; \
      $display("Error at %0t ns: got %h expected %h", $time, a, b); \
   end \
end
module testbench;
   import lcs_pkg::*;
   logic clk, rst_b, wb_we_i, wb_stb_i, wb_cyc_i, wb_ack_o, quiet;
   logic [7:0] wb_adr_i, byte_tx_bus, byte_rx_bus, tx_byte;
   logic [31:0] wb_dat_i, wb_dat_o, rdata;
   logic [3:0] wb_sel_i;
   logic serial_rx_in, serial_rx_clock_in, serial_tx_out, serial_tx_clock_out;
   logic byte_tx_clock_in, byte_rx_clock_out, synth_reference_clock;
   logic differential_reference_clock_p, differential_reference_clock_n;
   logic recovery_reference_clock, mult_clock, dropped_bit, drift_excess;
   logic synth_lock_indicator, recovery_lock_indicator;
   logic recovery_reference_out;
   logic [7:0] sh;
   int fails, tests_run, cycles, pulses;
   logic [2:0] rates [5] = '{RATE_19M, RATE_38M, RATE_51M, RATE_77M, 3'h7};
   logic [5:0] divs [5] =
      '{DIV_REF_19M, DIV_REF_38M, DIV_REF_51M, DIV_REF_77M, DIV_REF_77M};

   lcs_top lcs_top_inst (.clk(clk), .rst_b(rst_b), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
      .wb_stb_i(wb_stb_i), .wb_cyc_i(wb_cyc_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .serial_rx_in(serial_rx_in),
      .serial_rx_clock_in(serial_rx_clock_in),
      .serial_tx_out(serial_tx_out),
      .serial_tx_clock_out(serial_tx_clock_out),
      .byte_tx_bus(byte_tx_bus), .byte_tx_clock_in(byte_tx_clock_in),
      .byte_rx_bus(byte_rx_bus), .byte_rx_clock_out(byte_rx_clock_out),
      .synth_reference_clock(synth_reference_clock),
      .differential_reference_clock_p(differential_reference_clock_p),
      .differential_reference_clock_n(differential_reference_clock_n),
      .recovery_reference_clock(recovery_reference_clock),
      .mult_clock(mult_clock), .dropped_bit(dropped_bit),
      .drift_excess(drift_excess),
      .synth_lock_indicator(synth_lock_indicator),
      .recovery_lock_indicator(recovery_lock_indicator),
      .recovery_reference_out(recovery_reference_out));
   lcs_partner lcs_partner_inst (.clk(clk), .rst_b(rst_b), .quiet(quiet),
      .tx_byte(tx_byte), .serial_rx_in(serial_rx_in),
      .serial_rx_clock_in(serial_rx_clock_in), .byte_tx_bus(byte_tx_bus),
      .byte_tx_clock_in(byte_tx_clock_in),
      .synth_reference_clock(synth_reference_clock),
      .differential_reference_clock_p(differential_reference_clock_p),
      .differential_reference_clock_n(differential_reference_clock_n),
      .recovery_reference_clock(recovery_reference_clock),
      .mult_clock(mult_clock));

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic summarize();
      $display("comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // low lock pulses seen since reset
   always @(posedge clk) begin
      if (synth_lock_indicator === 1'b0) pulses++;
   end

   // hang guard, generous against about 1500 cycles of tests
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         summarize();
      end
   end

   task automatic wb_cycle(input logic we, input logic [7:0] adr,
                           input logic [31:0] wd, input logic [3:0] sel);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      wb_sel_i <= sel;
      @(posedge clk);
      while (wb_ack_o !== 1'b1) @(posedge clk);
      rdata = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask : wb_cycle

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      wb_cycle(1'b1, adr, d, 4'hf);
   endtask : wr

   task automatic rd(input logic [7:0] adr);
      wb_cycle(1'b0, adr, 32'h0, 4'hf);
   endtask : rd

   function automatic logic is_rot(input logic [7:0] v, input logic [7:0] p);
      is_rot = 1'b0;
      for (int k = 0; k < 8; k++) begin
         if (v === 8'((p << k) | (p >> (8 - k)))) is_rot = 1'b1;
      end
   endfunction : is_rot

   // serial pair, and byte pair when asked, lag their sources one cycle
   task automatic follow(input logic bytes);
      logic [1:0] ps;
      logic [8:0] pb;
      repeat (3) @(posedge clk);
      #1;
      repeat (16) begin
         ps = {serial_rx_clock_in, serial_rx_in};
         pb = {byte_tx_clock_in, byte_tx_bus};
         @(posedge clk);
         #1;
         `CHECK({serial_tx_clock_out, serial_tx_out}, ps)
         if (bytes) `CHECK({byte_rx_clock_out, byte_rx_bus}, pb)
      end
   endtask : follow

   task automatic follow_ref(input logic own);
      logic p;
      repeat (3) @(posedge clk);
      #1;
      repeat (16) begin
         p = own ? recovery_reference_clock :
             ~(differential_reference_clock_p ^ synth_reference_clock);
         @(posedge clk);
         #1;
         `CHECK(recovery_reference_out, p)
      end
   endtask : follow_ref

   initial begin
      rst_b = 1'b0;
      {wb_we_i, wb_stb_i, wb_cyc_i, quiet, dropped_bit, drift_excess} = '0;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h0;
      wb_sel_i = 4'h0;
      tx_byte = 8'h0f;
      @(posedge clk);
      #1;
      `CHECK({synth_lock_indicator, recovery_lock_indicator, wb_ack_o}, 3'h4)
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd(ADDR_CTRL);
      `CHECK(rdata, CTRL_RESET)
      wr(8'h08, 32'hffff_ffff);
      rd(8'h08);
      `CHECK(rdata, 32'h0)
      rd(ADDR_CTRL);
      `CHECK(rdata, CTRL_RESET)
      wb_cycle(1'b1, ADDR_CTRL, 32'h0000_0f3f, 4'h2);
      rd(ADDR_CTRL);
      `CHECK(rdata & 32'h0000_0f3f, 32'h0000_0f00)
      // divided edge lands two cycles after the reference edge
      `CHECK(pulses, 1)
      for (int i = 0; i < 5; i++) begin
         wr(ADDR_CTRL, {20'h0, i[0], rates[i], 8'h00});
         rd(ADDR_STATUS);
         `CHECK({rdata[ST_DIV_LSB +: 6], rdata[ST_HIGH_RATE]}, {divs[i], i[0]})
      end
      wr(ADDR_CTRL, 32'h0);
      repeat (64) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         #1;
         sh = {sh[6:0], serial_tx_out};
      end
      `CHECK(is_rot(sh, 8'h0f), 1'b1)
      `CHECK(is_rot(byte_rx_bus, 8'haa), 1'b1)
      wr(ADDR_CTRL, 32'h2);
      repeat (40) @(posedge clk);
      #1;
      `CHECK(is_rot(byte_rx_bus, 8'h0f), 1'b1)
      wr(ADDR_CTRL, 32'h4);
      repeat (40) @(posedge clk);
      #1;
      `CHECK(is_rot(byte_rx_bus, 8'h0f), 1'b1)
      wr(ADDR_CTRL, 32'h1);
      follow(1'b0);
      `CHECK(is_rot(byte_rx_bus, 8'haa), 1'b1)
      tx_byte <= 8'h3c;
      wr(ADDR_CTRL, 32'h3);
      follow(1'b1);
      wr(ADDR_CTRL, 32'h20);
      follow_ref(1'b1);
      wr(ADDR_CTRL, 32'h0);
      follow_ref(1'b0);
      wr(ADDR_CTRL, 32'h28);
      repeat (4) begin
         @(posedge clk);
         #1;
         sh[0] = serial_rx_clock_in;
         @(posedge clk);
         #1;
         `CHECK(serial_tx_clock_out, sh[0])
      end
      wr(ADDR_CTRL, 32'h30);
      rd(ADDR_STATUS);
      `CHECK(rdata[ST_REFSEL_ACT], 1'b1)
      wr(ADDR_CTRL, 32'h32);
      rd(ADDR_STATUS);
      `CHECK(rdata[ST_REFSEL_ACT], 1'b0)
      wr(ADDR_CTRL, 32'h30);
      quiet <= 1'b1;
      repeat (115) @(posedge clk);
      rd(ADDR_STATUS);
      `CHECK(rdata[ST_LOS], 1'b0)
      repeat (20) @(posedge clk);
      rd(ADDR_STATUS);
      `CHECK({rdata[ST_LOS], rdata[ST_REFSEL_ACT]}, 2'h2)
      `CHECK(byte_rx_bus, 8'h00)
      quiet <= 1'b0;
      rd(ADDR_STATUS);
      `CHECK(rdata[ST_LOS], 1'b1)
      // line toggles again, loss still held
      repeat (16) @(posedge clk);
      #1;
      `CHECK(byte_rx_bus, 8'h00)
      repeat (140) @(posedge clk);
      rd(ADDR_STATUS);
      `CHECK(rdata[ST_LOS], 1'b0)
      wr(ADDR_CTRL, 32'h0);
      repeat (400) @(posedge clk);
      #1;
      `CHECK(recovery_lock_indicator, 1'b1)
      quiet <= 1'b1;
      repeat (90) @(posedge clk);
      quiet <= 1'b0;
      repeat (4) @(posedge clk);
      #1;
      `CHECK(recovery_lock_indicator, 1'b1)
      @(posedge clk);
      dropped_bit <= 1'b1;
      @(posedge clk);
      dropped_bit <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHECK(recovery_lock_indicator, 1'b0)
      repeat (360) @(posedge clk);
      #1;
      `CHECK(recovery_lock_indicator, 1'b0)
      repeat (40) @(posedge clk);
      drift_excess <= 1'b1;
      #1;
      `CHECK(recovery_lock_indicator, 1'b1)
      @(posedge clk);
      drift_excess <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      `CHECK(recovery_lock_indicator, 1'b0)
      summarize();
   end
endmodule : testbench
